// File: pkg/clfc_pkg.sv
// Constants, register map and state codes for the current limit and fault control block.
// Assumes a 40 MHz mclk and a register port that an external serial front end drives.
package clfc_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CORD = 8'h0F;
  localparam logic [7:0] ADDR_SCALE = 8'h17;
  localparam logic [7:0] ADDR_INPUT_LIMIT_PIN = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // Field positions.
  localparam int CTRL_HIZ_BIT = 0;
  localparam int CTRL_IRQCLR_BIT = 1;
  localparam int STAT_KIND_BIT = 3;
  localparam int STAT_INREG_BIT = 4;
  localparam int STAT_IRQ_BIT = 5;

  // Reset values.
  localparam logic [6:0] SCALE_RST = 7'h64;
  localparam logic [1:0] INPUT_LIMIT_PIN_RST = 2'h1;
  localparam logic [1:0] CORD_RST = 2'h0;

  // Applied output scale bounds in percent.
  localparam logic [6:0] SCALE_MIN = 7'h01;
  localparam logic [6:0] SCALE_MAX = 7'h64;

  // Input limit field codes and percentages.
  localparam logic [1:0] INPUT_LIMIT_PIN_OFF = 2'h0;
  localparam logic [1:0] INPUT_LIMIT_PIN_150 = 2'h1;
  localparam logic [1:0] INPUT_LIMIT_PIN_200 = 2'h2;
  localparam logic [7:0] INPUT_LIMIT_PIN_PCT_OFF = 8'h00;
  localparam logic [7:0] INPUT_LIMIT_PIN_PCT_150 = 8'h96;
  localparam logic [7:0] INPUT_LIMIT_PIN_PCT_200 = 8'hC8;

  // Cord compensation codes and offsets in millivolts.
  localparam logic [1:0] CORD_100 = 2'h1;
  localparam logic [1:0] CORD_200 = 2'h2;
  localparam logic [1:0] CORD_300 = 2'h3;
  localparam logic [8:0] CORD_MV_0 = 9'h000;
  localparam logic [8:0] CORD_MV_100 = 9'h064;
  localparam logic [8:0] CORD_MV_200 = 9'h0C8;
  localparam logic [8:0] CORD_MV_300 = 9'h12C;

  // Power-on state status codes.
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] STAT_SS = 3'h1;
  localparam logic [2:0] STAT_HICCUP = 3'h2;
  localparam logic [2:0] STAT_LLDIS = 3'h3;
  localparam logic [2:0] STAT_OFF = 3'h0;

  // Timing.
  localparam int CLK_KHZ = 40000;
  localparam int HICCUP_MS = 3000;
  localparam int OVHOLD_MS = 100;
  localparam int HICCUP_CYC = HICCUP_MS * CLK_KHZ;
  localparam int OVHOLD_CYC = OVHOLD_MS * CLK_KHZ;

  // Synchroniser lanes for the comparator and pin inputs.
  localparam int NSYNC = 7;
  localparam int SY_EN = 0;
  localparam int SY_UV = 1;
  localparam int SY_OV = 2;
  localparam int SY_IOUT = 3;
  localparam int SY_IIN = 4;
  localparam int SY_SSDONE = 5;
  localparam int SY_LLOAD = 6;

  typedef enum logic [4:0] {
    ST_HIZ = 5'h01,
    ST_RST = 5'h02,
    ST_SS = 5'h04,
    ST_HICCUP = 5'h08,
    ST_LLDIS = 5'h10
  } clfc_state_t;

endpackage

// File: pkg/clfc_tmr_if.sv
// Run and done handshake between the fault control core and one interval timer.
// Assumes both ends sit on the same mclk.
`timescale 1ns/10ps
interface clfc_tmr_if;
  logic run;
  logic done;
  modport ctl (output run, input done);
  modport tmr (input run, output done);
endinterface

// File: logic/clfc_timer.sv
// Interval timer: done rises after run has been held for LEN cycles.
// Assumes run comes from logic on mclk; dropping run restarts the count.
`timescale 1ns/10ps
module clfc_timer #(
  parameter int LEN = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  clfc_tmr_if.tmr t
);
  logic [31:0] cnt_r;
  logic done_r;
  wire last = (cnt_r == 32'(LEN - 1));

  always_ff @(posedge mclk) begin
    if (!rst_n || !t.run) begin
      cnt_r <= 32'h0000_0000;
      done_r <= 1'b0;
    end else if (last) begin
      done_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  assign t.done = done_r;

  property p_tmr_clear;
    @(posedge mclk) disable iff (!rst_n) !t.run |=> (!t.done && cnt_r == 32'h0000_0000);
  endproperty
  a_tmr_clear: assert property (p_tmr_clear) else $error("timer not cleared when run dropped");

  property p_tmr_len;
    @(posedge mclk) disable iff (!rst_n) (t.run && last && !t.done) |=> t.done;
  endproperty
  a_tmr_len: assert property (p_tmr_len) else $error("timer did not finish at its length");
endmodule

// File: logic/clfc_core.sv
// Current limit, regulation status and fault control for the buck-boost converter.
// Assumes analog comparator levels arrive asynchronously and a serial front end drives the register port.
`timescale 1ns/10ps

// Notes on behaviour
// - Seven-bit output scale sets the output limit in one percent steps.
// - A written zero reads back zero but applies one percent.
// - Values above one hundred read back unchanged but apply one hundred percent.
// - Output current above the scaled limit switches regulation to constant current.
// - Read-only status bit shows 0 for constant voltage, 1 for constant current.
// - Output undervoltage is a fault: hiccup with output off for three seconds.
// - After hiccup go to restart, and repeat while the fault stays.
// - Input current is watched outside high-impedance mode; reaching the limit starts input regulation.
// - Input scale 00 off, 01 150%, 10 200%, 11 150%.
// - Output overvoltage above 108 percent stops switching at once.
// - Overvoltage lasting over 100 ms forces high-impedance mode.
// - Cord compensation 00 off, 01 100 mV, 10 200 mV, 11 300 mV.
// - Entering hiccup asserts the low interrupt until software writes the clear bit.
// - Status code 000 restart, 001 soft start, 010 hiccup, 011 light-load, else 000.
module clfc_core #(
  parameter int HICCUP_CYC = clfc_pkg::HICCUP_CYC,
  parameter int OVHOLD_CYC = clfc_pkg::OVHOLD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pin and comparator levels
  input wire logic converter_en,
  input wire logic vout_uv,
  input wire logic vout_ov,
  input wire logic iout_over,
  input wire logic iin_at_limit,
  input wire logic soft_start_done,
  input wire logic light_load,
  // Converter control
  output logic switching_en,
  output logic high_impedance_mode,
  output logic regulation_kind_flag,
  output logic input_regulating,
  output logic [6:0] applied_out_scale,
  output logic [7:0] input_limit_pct,
  output logic [8:0] cord_comp_mv,
  output logic [2:0] pon_status,
  output logic interrupt_out_n
);
  clfc_tmr_if hic_if ();
  clfc_tmr_if ov_if ();

  logic [clfc_pkg::NSYNC-1:0] meta_r;
  logic [clfc_pkg::NSYNC-1:0] sync_r;
  logic [6:0] output_current_scale_r;
  logic [1:0] input_limit_scale_r;
  logic [1:0] cord_comp_r;
  logic hiz_req_r;
  clfc_pkg::clfc_state_t state_r;
  clfc_pkg::clfc_state_t state_nxt;
  logic switching_en_r;
  logic high_impedance_mode_r;
  logic regulation_kind_flag_r;
  logic input_regulating_r;
  logic [6:0] applied_out_scale_r;
  logic [7:0] input_limit_pct_r;
  logic [8:0] cord_comp_mv_r;
  logic [2:0] pon_status_r;
  logic interrupt_out_n_r;
  logic interrupt_out_n_nxt;
  logic [7:0] reg_rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] status_word;
  logic [7:0] ctrl_word;

  // Pin and comparator levels gathered into one synchroniser lane each.
  wire [clfc_pkg::NSYNC-1:0] pin_vec;
  assign pin_vec[clfc_pkg::SY_EN] = converter_en;
  assign pin_vec[clfc_pkg::SY_UV] = vout_uv;
  assign pin_vec[clfc_pkg::SY_OV] = vout_ov;
  assign pin_vec[clfc_pkg::SY_IOUT] = iout_over;
  assign pin_vec[clfc_pkg::SY_IIN] = iin_at_limit;
  assign pin_vec[clfc_pkg::SY_SSDONE] = soft_start_done;
  assign pin_vec[clfc_pkg::SY_LLOAD] = light_load;

  // Only the second stage is read, so a metastable first stage never reaches logic.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pin_vec;
      sync_r <= meta_r;
    end
  end

  wire en_s = sync_r[clfc_pkg::SY_EN];
  wire uv_s = sync_r[clfc_pkg::SY_UV];
  wire ov_s = sync_r[clfc_pkg::SY_OV];
  wire iout_s = sync_r[clfc_pkg::SY_IOUT];
  wire iin_s = sync_r[clfc_pkg::SY_IIN];
  wire ssdone_s = sync_r[clfc_pkg::SY_SSDONE];
  wire lload_s = sync_r[clfc_pkg::SY_LLOAD];

  // Register write strobes.
  wire wr_ctrl = reg_wr && (reg_addr == clfc_pkg::ADDR_CTRL);
  wire wr_cord = reg_wr && (reg_addr == clfc_pkg::ADDR_CORD);
  wire wr_scale = reg_wr && (reg_addr == clfc_pkg::ADDR_SCALE);
  wire wr_input_limit_pin = reg_wr && (reg_addr == clfc_pkg::ADDR_INPUT_LIMIT_PIN);

  // The stored scale is kept as written; only the applied value is clamped.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      output_current_scale_r <= clfc_pkg::SCALE_RST;
      input_limit_scale_r <= clfc_pkg::INPUT_LIMIT_PIN_RST;
      cord_comp_r <= clfc_pkg::CORD_RST;
      hiz_req_r <= 1'b0;
    end else begin
      if (wr_scale) begin
        output_current_scale_r <= reg_wdata[6:0];
      end
      if (wr_input_limit_pin) begin
        input_limit_scale_r <= reg_wdata[1:0];
      end
      if (wr_cord) begin
        cord_comp_r <= reg_wdata[1:0];
      end
      if (wr_ctrl) begin
        hiz_req_r <= reg_wdata[clfc_pkg::CTRL_HIZ_BIT];
      end
    end
  end

  // Interval timers.
  clfc_timer #(.LEN(HICCUP_CYC)) i_hic_tmr (
    .mclk(mclk),
    .rst_n(rst_n),
    .t(hic_if.tmr)
  );
  clfc_timer #(.LEN(OVHOLD_CYC)) i_ov_tmr (
    .mclk(mclk),
    .rst_n(rst_n),
    .t(ov_if.tmr)
  );

  wire powered_on = (state_r != clfc_pkg::ST_HIZ);
  assign hic_if.run = (state_r == clfc_pkg::ST_HICCUP);
  assign ov_if.run = ov_s && powered_on;
  wire leave_pon = !en_s || hiz_req_r || ov_if.done;

  // Power-on state machine; a standing overvoltage keeps it out of power-on.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      clfc_pkg::ST_HIZ: begin
        if (en_s && !hiz_req_r && !ov_s) begin
          state_nxt = clfc_pkg::ST_RST;
        end
      end
      clfc_pkg::ST_RST: begin
        state_nxt = clfc_pkg::ST_SS;
      end
      clfc_pkg::ST_SS: begin
        if (uv_s) begin
          state_nxt = clfc_pkg::ST_HICCUP;
        end else if (lload_s && ssdone_s) begin
          state_nxt = clfc_pkg::ST_LLDIS;
        end
      end
      clfc_pkg::ST_HICCUP: begin
        if (hic_if.done) begin
          state_nxt = clfc_pkg::ST_RST;
        end
      end
      clfc_pkg::ST_LLDIS: begin
        state_nxt = clfc_pkg::ST_LLDIS;
      end
      default: begin
        state_nxt = clfc_pkg::ST_HIZ;
      end
    endcase
    if (powered_on && leave_pon) begin
      state_nxt = clfc_pkg::ST_HIZ;
    end
  end

  // Decodes of the configuration fields.
  wire [6:0] scale_applied = (output_current_scale_r == 7'h00) ? clfc_pkg::SCALE_MIN
    : ((output_current_scale_r > clfc_pkg::SCALE_MAX) ? clfc_pkg::SCALE_MAX : output_current_scale_r);
  wire [7:0] input_limit_pin_pct = (input_limit_scale_r == clfc_pkg::INPUT_LIMIT_PIN_OFF) ? clfc_pkg::INPUT_LIMIT_PIN_PCT_OFF
    : ((input_limit_scale_r == clfc_pkg::INPUT_LIMIT_PIN_200) ? clfc_pkg::INPUT_LIMIT_PIN_PCT_200 : clfc_pkg::INPUT_LIMIT_PIN_PCT_150);
  wire [8:0] cord_mv = (cord_comp_r == clfc_pkg::CORD_100) ? clfc_pkg::CORD_MV_100
    : ((cord_comp_r == clfc_pkg::CORD_200) ? clfc_pkg::CORD_MV_200
    : ((cord_comp_r == clfc_pkg::CORD_300) ? clfc_pkg::CORD_MV_300 : clfc_pkg::CORD_MV_0));
  wire [2:0] status_code = (state_nxt == clfc_pkg::ST_RST) ? clfc_pkg::STAT_RST
    : ((state_nxt == clfc_pkg::ST_SS) ? clfc_pkg::STAT_SS
    : ((state_nxt == clfc_pkg::ST_HICCUP) ? clfc_pkg::STAT_HICCUP
    : ((state_nxt == clfc_pkg::ST_LLDIS) ? clfc_pkg::STAT_LLDIS : clfc_pkg::STAT_OFF)));
  wire switch_nxt = (state_nxt == clfc_pkg::ST_SS) && !ov_s;
  wire kind_nxt = iout_s && (state_nxt == clfc_pkg::ST_SS);
  wire inreg_nxt = iin_s && (input_limit_scale_r != clfc_pkg::INPUT_LIMIT_PIN_OFF)
    && (state_nxt != clfc_pkg::ST_HIZ);

  // Entry into hiccup wins over a clear written in the same cycle.
  wire irq_set = (state_nxt == clfc_pkg::ST_HICCUP) && (state_r != clfc_pkg::ST_HICCUP);
  wire irq_clr = wr_ctrl && reg_wdata[clfc_pkg::CTRL_IRQCLR_BIT];
  assign interrupt_out_n_nxt = irq_set ? 1'b0 : (irq_clr ? 1'b1 : interrupt_out_n_r);

  always_comb begin
    status_word = 8'h00;
    status_word[2:0] = pon_status_r;
    status_word[clfc_pkg::STAT_KIND_BIT] = regulation_kind_flag_r;
    status_word[clfc_pkg::STAT_INREG_BIT] = input_regulating_r;
    status_word[clfc_pkg::STAT_IRQ_BIT] = !interrupt_out_n_r;
  end

  always_comb begin
    ctrl_word = 8'h00;
    ctrl_word[clfc_pkg::CTRL_HIZ_BIT] = hiz_req_r;
  end

  // The clear bit always reads back zero.
  always_comb begin
    if (reg_addr == clfc_pkg::ADDR_CTRL) begin
      rdata_nxt = ctrl_word;
    end else if (reg_addr == clfc_pkg::ADDR_CORD) begin
      rdata_nxt = {6'h00, cord_comp_r};
    end else if (reg_addr == clfc_pkg::ADDR_SCALE) begin
      rdata_nxt = {1'b0, output_current_scale_r};
    end else if (reg_addr == clfc_pkg::ADDR_INPUT_LIMIT_PIN) begin
      rdata_nxt = {6'h00, input_limit_scale_r};
    end else if (reg_addr == clfc_pkg::ADDR_STATUS) begin
      rdata_nxt = status_word;
    end else begin
      rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= clfc_pkg::ST_HIZ;
      switching_en_r <= 1'b0;
      high_impedance_mode_r <= 1'b1;
      regulation_kind_flag_r <= 1'b0;
      input_regulating_r <= 1'b0;
      applied_out_scale_r <= clfc_pkg::SCALE_RST;
      input_limit_pct_r <= clfc_pkg::INPUT_LIMIT_PIN_PCT_150;
      cord_comp_mv_r <= clfc_pkg::CORD_MV_0;
      pon_status_r <= clfc_pkg::STAT_OFF;
      interrupt_out_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      switching_en_r <= switch_nxt;
      high_impedance_mode_r <= (state_nxt == clfc_pkg::ST_HIZ);
      regulation_kind_flag_r <= kind_nxt;
      input_regulating_r <= inreg_nxt;
      applied_out_scale_r <= scale_applied;
      input_limit_pct_r <= input_limit_pin_pct;
      cord_comp_mv_r <= cord_mv;
      pon_status_r <= status_code;
      interrupt_out_n_r <= interrupt_out_n_nxt;
    end
  end

  // Read data holds until the next read strobe.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign switching_en = switching_en_r;
  assign high_impedance_mode = high_impedance_mode_r;
  assign regulation_kind_flag = regulation_kind_flag_r;
  assign input_regulating = input_regulating_r;
  assign applied_out_scale = applied_out_scale_r;
  assign input_limit_pct = input_limit_pct_r;
  assign cord_comp_mv = cord_comp_mv_r;
  assign pon_status = pon_status_r;
  assign interrupt_out_n = interrupt_out_n_r;

  sequence s_enter_hiccup;
    (state_r != clfc_pkg::ST_HICCUP) ##1 (state_r == clfc_pkg::ST_HICCUP);
  endsequence

  property p_irq_on_hiccup;
    @(posedge mclk) disable iff (!rst_n) s_enter_hiccup |-> !interrupt_out_n;
  endproperty
  a_irq_on_hiccup: assert property (p_irq_on_hiccup) else $error("interrupt not asserted on hiccup entry");

  property p_ov_stops;
    @(posedge mclk) disable iff (!rst_n) sync_r[clfc_pkg::SY_OV] |=> !switching_en;
  endproperty
  a_ov_stops: assert property (p_ov_stops) else $error("switching continued during overvoltage");

  property p_hiz_status;
    @(posedge mclk) disable iff (!rst_n) high_impedance_mode |-> (pon_status == clfc_pkg::STAT_OFF);
  endproperty
  a_hiz_status: assert property (p_hiz_status) else $error("status not zero outside power-on");

  property p_kind_cc;
    @(posedge mclk) disable iff (!rst_n) regulation_kind_flag |-> $past(sync_r[clfc_pkg::SY_IOUT]);
  endproperty
  a_kind_cc: assert property (p_kind_cc) else $error("constant current flagged without overcurrent");

  property p_scale_clamp;
    @(posedge mclk) disable iff (!rst_n)
      (applied_out_scale >= clfc_pkg::SCALE_MIN) && (applied_out_scale <= clfc_pkg::SCALE_MAX);
  endproperty
  a_scale_clamp: assert property (p_scale_clamp) else $error("applied output scale out of range");
endmodule

// File: bench/current_limit_fault_control_bench.sv
// Self-checking bench for the current limit and fault control core.
// Assumes one-cycle register strobes and short interval parameters.
`timescale 1ns/10ps
module current_limit_fault_control_bench;
  logic mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic en = 1'b0, uv = 1'b0, ov = 1'b0, io = 1'b0, ii = 1'b0, ssd = 1'b0, ll = 1'b0;
  wire logic [8:0] ccm;
  wire logic [7:0] rdat, ilp;
  wire logic [6:0] aos;
  wire logic [2:0] pst;
  wire logic swe, himp, rkf, inr, irqn;
  logic [6:0] corner [5] = '{7'h00, 7'h01, 7'h64, 7'h65, 7'h7F};
  logic [6:0] v;
  int errors = 0, n_compared = 0;
  clfc_core #(.HICCUP_CYC(40), .OVHOLD_CYC(30)) i_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdat), .converter_en(en),
    .vout_uv(uv), .vout_ov(ov), .iout_over(io), .iin_at_limit(ii), .soft_start_done(ssd), .light_load(ll),
    .switching_en(swe), .high_impedance_mode(himp), .regulation_kind_flag(rkf), .input_regulating(inr),
    .applied_out_scale(aos), .input_limit_pct(ilp), .cord_comp_mv(ccm), .pon_status(pst),
    .interrupt_out_n(irqn));
  initial forever #12.5 mclk = ~mclk;
  function automatic logic [6:0] e_sc(input logic [6:0] s);
    return s == 7'h00 ? clfc_pkg::SCALE_MIN : (s > clfc_pkg::SCALE_MAX ? clfc_pkg::SCALE_MAX : s);
  endfunction
  function automatic logic [7:0] e_il(input logic [1:0] c);
    return c == clfc_pkg::INPUT_LIMIT_PIN_OFF ? clfc_pkg::INPUT_LIMIT_PIN_PCT_OFF
      : (c == clfc_pkg::INPUT_LIMIT_PIN_200 ? clfc_pkg::INPUT_LIMIT_PIN_PCT_200 : clfc_pkg::INPUT_LIMIT_PIN_PCT_150);
  endfunction
  function automatic logic [8:0] e_cd(input logic [1:0] c);
    return 9'(c) * 9'h064;
  endfunction
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // The span covers every scenario with a wide margin.
  initial begin
    #200us;
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h4126B6F0));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(aos, clfc_pkg::SCALE_RST);
    for (int i = 0; i < 12; i++) begin
      v = i < 5 ? corner[i] : 7'($urandom);
      acc(1'b1, clfc_pkg::ADDR_SCALE, {1'b0, v});
      chk(aos, e_sc(v));
      acc(1'b0, clfc_pkg::ADDR_SCALE, 8'h00);
      chk(rdat[6:0], v);
      acc(1'b1, clfc_pkg::ADDR_INPUT_LIMIT_PIN, 8'(i % 4));
      chk(ilp, e_il(2'(i)));
      acc(1'b1, clfc_pkg::ADDR_CORD, 8'(i % 4));
      chk(ccm, e_cd(2'(i)));
    end
    en <= 1'b1;
    ssd <= 1'b1;
    io <= 1'b1;
    ii <= 1'b1;
    repeat (12) @(posedge mclk);
    chk(rkf, 1'b1);
    chk(swe, 1'b1);
    chk(pst, clfc_pkg::STAT_SS);
    chk(inr, 1'b1);
    acc(1'b0, clfc_pkg::ADDR_STATUS, 8'h00);
    chk(rdat[clfc_pkg::STAT_KIND_BIT], 1'b1);
    io <= 1'b0;
    uv <= 1'b1;
    repeat (12) @(posedge mclk);
    chk(rkf, 1'b0);
    chk(pst, clfc_pkg::STAT_HICCUP);
    chk(irqn, 1'b0);
    uv <= 1'b0;
    repeat (60) @(posedge mclk);
    acc(1'b1, clfc_pkg::ADDR_CTRL, 8'h02);
    chk(irqn, 1'b1);
    ov <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(swe, 1'b0);
    repeat (40) @(posedge mclk);
    chk(himp, 1'b1);
    chk(pst, clfc_pkg::STAT_OFF);
    ov <= 1'b0;
    ll <= 1'b1;
    repeat (12) @(posedge mclk);
    chk(pst, clfc_pkg::STAT_LLDIS);
    tally_and_finish();
  end
endmodule
